// ---- rtl/encoder_out_gen.sv ----
`timescale 1ns/10ps
module encoder_out_gen (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_step,
    input  wire logic        i_cw,
    input  wire logic [15:0] i_lines,
    output logic             o_a,
    output logic             o_b,
    output logic             o_z
);
    logic [1:0]  phase_q;
    logic [1:0]  phase_d;
    logic [15:0] line_q;
    logic [15:0] line_d;
    logic [15:0] last_line;

    // Zero lines would stall the marker, so treat it as one
    assign last_line = (i_lines == 16'h0000) ? 16'h0000 : i_lines - 16'h0001;

    // ============================================================
    // Phase walk: 00,10,11,01 with A as the leading channel
    always_comb begin
        phase_d = phase_q;
        line_d  = line_q;
        if (i_step) begin
            if (i_cw) begin
                phase_d = phase_q + 2'h1;
                if (phase_q == 2'h3) begin
                    line_d = (line_q >= last_line) ? 16'h0000 : line_q + 16'h0001;
                end
            end else begin
                phase_d = phase_q - 2'h1;
                if (phase_q == 2'h0) begin
                    line_d = (line_q == 16'h0000) ? last_line : line_q - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase_q <= 2'h0;
            line_q  <= 16'h0000;
            o_a     <= 1'b0;
            o_b     <= 1'b0;
            o_z     <= 1'b0;
        end else begin
            phase_q <= phase_d;
            line_q  <= line_d;
            o_a     <= (phase_d == 2'h1) || (phase_d == 2'h2);
            o_b     <= (phase_d == 2'h2) || (phase_d == 2'h3);
            // One line index per turn, gated by B high
            o_z     <= (line_d == 16'h0000) && phase_d[1];
        end
    end
endmodule

// ---- rtl/pulse_io_top.sv ----
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "pulse_io_regs.svh"
module pulse_io_top (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Pulse input connector
    input  wire logic        i_chan_a,
    input  wire logic        i_chan_b,
    input  wire logic        i_marker,
    input  wire logic        i_autobaud_jumper,
    // Serial mode switch
    input  wire logic [3:0]  i_serial_switch,
    // Motor shaft motion for the equivalent output
    input  wire logic        i_motor_step,
    input  wire logic        i_motor_cw,
    // Serial port setup
    output logic             o_serial_rs485,
    output logic [3:0]       o_node_address,
    output logic             o_autobaud_en,
    output logic [15:0]      o_baud_rate,
    output logic             o_setup_valid,
    // Decoded command motion
    output logic             o_cmd_step,
    output logic             o_cmd_cw,
    // Encoder-equivalent output
    output logic             o_enc_a,
    output logic             o_enc_b,
    output logic             o_enc_z
);
    // ============================================================
    // Pin synchronisers
    logic [7:0] pins_raw;
    logic [7:0] pins_s;
    logic       a_s;
    logic       b_s;
    logic       z_s;
    logic       jumper_s;
    logic [3:0] switch_s;

    assign pins_raw = {i_serial_switch, i_autobaud_jumper, i_marker, i_chan_b, i_chan_a};

    sync_two_ff #(
        .WIDTH (8)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (pins_raw),
        .o_sync  (pins_s)
    );

    assign a_s      = pins_s[0];
    assign b_s      = pins_s[1];
    assign z_s      = pins_s[2];
    assign jumper_s = pins_s[3];
    assign switch_s = pins_s[7:4];

    // ============================================================
    // Register storage
    logic [2:0]  mode_q;
    logic [15:0] baud_q;
    logic [15:0] lines_q;
    logic [31:0] position_q;
    logic        qerr_q;
    logic        marker_q;

    // ============================================================
    // APB decode
    logic        setup_phase;
    logic        wr_en;
    logic        addr_hit;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign setup_phase = i_psel && !i_penable;
    // Zero wait states: pready rises on the first access cycle
    assign wr_en = i_psel && i_penable && i_pwrite && o_pready;

    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 32'h0000_0000;
        case (i_paddr)
            `REG_CTRL_OFS: begin
                rd_mux = {29'h0000_0000, mode_q};
            end
            `REG_BAUD_OFS: begin
                rd_mux = {16'h0000, baud_q};
            end
            `REG_LINES_OFS: begin
                rd_mux = {16'h0000, lines_q};
            end
            `REG_STATUS_OFS: begin
                rd_mux = status_word;
            end
            `REG_POSITION_OFS: begin
                rd_mux = position_q;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Read data latched in setup so the bus output is a flop
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= setup_phase;
            o_pslverr <= setup_phase && !addr_hit;
            if (setup_phase && !i_pwrite) begin
                o_prdata <= rd_mux;
            end
        end
    end

    // ============================================================
    // Control registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_q <= `CTRL_RESET;
        end else if (wr_en && i_paddr == `REG_CTRL_OFS) begin
            mode_q <= i_pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            baud_q <= `BAUD_RESET;
        end else if (wr_en && i_paddr == `REG_BAUD_OFS) begin
            baud_q <= i_pwdata[15:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lines_q <= `LINES_RESET;
        end else if (wr_en && i_paddr == `REG_LINES_OFS) begin
            lines_q <= i_pwdata[15:0];
        end
    end

    // ============================================================
    // Power-up capture of switch and jumper
    pulse_io_pkg::pwrup_type pu_q;
    logic [2:0]              settle_q;

    // Wait for the synchronisers to fill before trusting the pins
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pu_q     <= pulse_io_pkg::PU_SETTLE;
            settle_q <= 3'h0;
        end else begin
            case (pu_q)
                pulse_io_pkg::PU_SETTLE: begin
                    settle_q <= settle_q + 3'h1;
                    if (settle_q == `PWRUP_SETTLE_CYCLES - 3'h1) begin
                        pu_q <= pulse_io_pkg::PU_CAPTURE;
                    end
                end
                pulse_io_pkg::PU_CAPTURE: begin
                    pu_q <= pulse_io_pkg::PU_DONE;
                end
                pulse_io_pkg::PU_DONE: begin
                    pu_q <= pulse_io_pkg::PU_DONE;
                end
                default: begin
                    pu_q <= pulse_io_pkg::PU_SETTLE;
                end
            endcase
        end
    end

    // Only RXD and TXD exist, so nothing here waits on handshake
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_serial_rs485 <= 1'b0;
            o_node_address <= 4'h0;
            o_autobaud_en  <= 1'b0;
            o_setup_valid  <= 1'b0;
        end else if (pu_q == pulse_io_pkg::PU_CAPTURE) begin
            o_serial_rs485 <= (switch_s != 4'h0);
            o_node_address <= switch_s;
            o_autobaud_en  <= jumper_s;
            o_setup_valid  <= 1'b1;
        end
    end

    // Stored rate applies whenever auto-baud is off
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_baud_rate <= `BAUD_RESET;
        end else begin
            o_baud_rate <= baud_q;
        end
    end

    // ============================================================
    // Input decode
    pulse_io_pkg::fmt_type fmt;
    logic a_p_q;
    logic b_p_q;
    logic a_edge;
    logic b_edge;
    logic a_rise;
    logic b_rise;
    logic step;
    logic cw;
    logic both_edge;

    always_comb begin
        case (mode_q)
            3'h4: begin
                fmt = pulse_io_pkg::FMT_QUAD;
            end
            3'h5, 3'h6: begin
                fmt = pulse_io_pkg::FMT_STEP_DIR;
            end
            3'h7: begin
                fmt = pulse_io_pkg::FMT_CW_CCW;
            end
            default: begin
                fmt = pulse_io_pkg::FMT_NONE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            a_p_q <= 1'b0;
            b_p_q <= 1'b0;
        end else begin
            a_p_q <= a_s;
            b_p_q <= b_s;
        end
    end

    assign a_edge    = a_s ^ a_p_q;
    assign b_edge    = b_s ^ b_p_q;
    assign a_rise    = a_s && !a_p_q;
    assign b_rise    = b_s && !b_p_q;
    assign both_edge = a_edge && b_edge;

    // Marker is never an input to this decode
    always_comb begin
        step = 1'b0;
        cw   = 1'b1;
        case (fmt)
            pulse_io_pkg::FMT_QUAD: begin
                // Every single-channel edge counts, direction from phase
                step = (a_edge ^ b_edge);
                // A leading B means clockwise
                cw   = a_edge ? (a_s != b_s) : (a_s == b_s);
            end
            pulse_io_pkg::FMT_STEP_DIR: begin
                step = a_rise;
                cw   = !b_s;
            end
            pulse_io_pkg::FMT_CW_CCW: begin
                // Coincident pulses cancel out
                step = a_rise ^ b_rise;
                cw   = a_rise;
            end
            default: begin
                step = 1'b0;
                cw   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_cmd_step <= 1'b0;
            o_cmd_cw   <= 1'b1;
        end else begin
            o_cmd_step <= step;
            o_cmd_cw   <= cw;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            position_q <= 32'h0000_0000;
        end else if (step) begin
            position_q <= cw ? position_q + 32'h0000_0001 : position_q - 32'h0000_0001;
        end
    end

    // Sticky error; a new error in the clearing cycle wins
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            qerr_q <= 1'b0;
        end else if (fmt == pulse_io_pkg::FMT_QUAD && both_edge) begin
            qerr_q <= 1'b1;
        end else if (wr_en && i_paddr == `REG_STATUS_OFS && i_pwdata[`STAT_QERR_BIT]) begin
            qerr_q <= 1'b0;
        end
    end

    // Visible for diagnostics only
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            marker_q <= 1'b0;
        end else begin
            marker_q <= z_s;
        end
    end

    // ============================================================
    // Status word
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STAT_NODE_MSB:0]   = o_node_address;
        status_word[`STAT_RS485_BIT]    = o_serial_rs485;
        status_word[`STAT_ABAUD_BIT]    = o_autobaud_en;
        status_word[`STAT_QERR_BIT]     = qerr_q;
        status_word[`STAT_MARKER_BIT]   = marker_q;
        status_word[`STAT_CAPTURED_BIT] = o_setup_valid;
    end

    // ============================================================
    // Encoder-equivalent output
    encoder_out_gen u_enc_out (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_step  (i_motor_step),
        .i_cw    (i_motor_cw),
        .i_lines (lines_q),
        .o_a     (o_enc_a),
        .o_b     (o_enc_b),
        .o_z     (o_enc_z)
    );
endmodule

// ---- rtl/sync_two_ff.sv ----
`timescale 1ns/10ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    // ============================================================
    // First stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ---- shared/pulse_io_pkg.sv ----
package pulse_io_pkg;
    // ============================================================
    // Input decode formats
    typedef enum logic [1:0] {
        FMT_NONE,
        FMT_QUAD,
        FMT_STEP_DIR,
        FMT_CW_CCW
    } fmt_type;

    // ============================================================
    // Power-up capture states
    typedef enum logic [1:0] {
        PU_SETTLE,
        PU_CAPTURE,
        PU_DONE
    } pwrup_type;
endpackage

// ---- shared/pulse_io_regs.svh ----
`ifndef PULSE_IO_REGS_SVH
`define PULSE_IO_REGS_SVH
// ============================================================
// How it works
// - Rotary switch at zero selects point-to-point RS-232 serial operation.
// - Non-zero switch selects RS-485, switch value becomes node address.
// - Serial link uses only transmit and receive data, no handshake lines.
// - Mode 4 decodes channels A and B as quadrature encoder.
// - Modes 5 and 6: A is step pulse, B is direction level.
// - Mode 7: A pulses step clockwise, B pulses step counter-clockwise.
// - Marker input is accepted but never alters position or mode.
// - Auto-baud jumper sampled once at power-up; present enables auto-baud.
// - Jumper absent: serial port opens at the stored baud setting.
// - Encoder-equivalent output gives quadrature A, B and a marker.
// - Clockwise rotation: A leads B, on inputs and outputs alike.
// - Exactly one marker per revolution, coinciding with a B pulse.

// ============================================================
// Register byte offsets
`define REG_CTRL_OFS       8'h00
`define REG_BAUD_OFS       8'h04
`define REG_LINES_OFS      8'h08
`define REG_STATUS_OFS     8'h0C
`define REG_POSITION_OFS   8'h10

// ============================================================
// Field positions
`define CTRL_MODE_LSB      0
`define CTRL_MODE_MSB      2
`define STAT_NODE_MSB      3
`define STAT_RS485_BIT     4
`define STAT_ABAUD_BIT     5
`define STAT_QERR_BIT      6
`define STAT_MARKER_BIT    7
`define STAT_CAPTURED_BIT  8

// ============================================================
// Reset values and timing
`define CTRL_RESET         3'h0
`define BAUD_RESET         16'h2580
`define LINES_RESET        16'h0400
`define PWRUP_SETTLE_CYCLES 3'h4
`endif

// ---- verification/encoder_pulse_io_and_port_select_tb_top.sv ----
`timescale 1ns/10ps
module encoder_pulse_io_and_port_select_tb_top;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, perr, jmp, mstep, mcw;
    logic        rs485, abaud, valid, cmd_step, cmd_cw, enc_a, enc_b, enc_z, cha, chb, mrk;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  sw, node;
    logic [15:0] baud;
    int          n_errors, samples_checked, ncw, nccw;

    pulse_io_top dut (.i_clk(clk), .i_reset(reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_chan_a(cha), .i_chan_b(chb), .i_marker(mrk), .i_autobaud_jumper(jmp), .i_serial_switch(sw),
        .i_motor_step(mstep), .i_motor_cw(mcw), .o_serial_rs485(rs485), .o_node_address(node),
        .o_autobaud_en(abaud), .o_baud_rate(baud), .o_setup_valid(valid), .o_cmd_step(cmd_step),
        .o_cmd_cw(cmd_cw), .o_enc_a(enc_a), .o_enc_b(enc_b), .o_enc_z(enc_z));
    pulse_source src (.i_clk(clk), .o_chan_a(cha), .o_chan_b(chb), .o_marker(mrk));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        ncw  += (cmd_step === 1'b1 && cmd_cw === 1'b1);
        nccw += (cmd_step === 1'b1 && cmd_cw !== 1'b1);
    end
    // ============================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        n_errors += (k >= 16);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic rst(input logic [3:0] s, input logic j);
        int k;
        @(posedge clk);
        reset <= 1'b1;
        sw <= s;
        jmp <= j;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        k = 0;
        while (valid !== 1'b1 && k < 16) begin
            @(posedge clk);
            k++;
        end
        n_errors += (k >= 16);
    endtask
    // Settle past the sync and decode delay before judging counts
    task automatic counts(input int cw, input int ccw);
        repeat (6) @(posedge clk);
        chk(ncw, cw);
        chk(nccw, ccw);
        ncw = 0;
        nccw = 0;
    endtask
    task automatic mot(input logic d);
        @(posedge clk);
        mstep <= 1'b1;
        mcw <= d;
        @(posedge clk);
        mstep <= 1'b0;
        @(posedge clk);
    endtask
    // ============================================================
    // Scenarios
    task automatic t_setup();
        logic [3:0] s [3] = '{4'h0, 4'h5, 4'hF};
        for (int i = 0; i < 3; i++) begin
            rst(s[i], i[0]);
            chk(rs485, s[i] != 4'h0);
            chk(node, s[i]);
            chk(abaud, i[0]);
            sw <= ~s[i];
            jmp <= ~i[0];
            repeat (8) @(posedge clk);
            chk({node, abaud}, {s[i], i[0]});
        end
    endtask
    task automatic t_regs();
        rst(4'h3, 1'b0);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h2580);
        rdc(8'h08, 32'h400);
        rdc(8'h0C, 32'h113);
        chk({cmd_cw, baud}, 32'h12580);
        apb(1'b1, 8'h04, 32'h4B00);
        repeat (2) @(posedge clk);
        chk(baud, 32'h4B00);
        rdc(8'h20, 32'h0);
        chk(perr, 1'b1);
    endtask
    task automatic t_quad();
        apb(1'b1, 8'h00, 32'h4);
        rdc(8'h10, 32'h0);
        src.quad(1'b1, 8);
        counts(8, 0);
        src.quad(1'b0, 5);
        counts(0, 5);
        rdc(8'h10, 32'h3);
        src.both();
        counts(0, 0);
        rdc(8'h0C, 32'h153);
        apb(1'b1, 8'h0C, 32'h40);
        rdc(8'h0C, 32'h113);
        src.mark(3);
        counts(0, 0);
        rdc(8'h0C, 32'h193);
        rdc(8'h10, 32'h3);
        src.mark(1);
    endtask
    task automatic t_modes();
        for (int m = 5; m < 7; m++) begin
            apb(1'b1, 8'h00, 32'(m));
            src.lvl(1'b0, 1'b0);
            counts(0, 0);
            src.dir(1'b1, 3);
            counts(3, 0);
            src.dir(1'b0, 2);
            counts(0, 2);
        end
        apb(1'b1, 8'h00, 32'h7);
        // Direction level left B high; drop it so every B pulse is a rise
        src.lvl(1'b0, 1'b0);
        src.pulse(1'b0, 3);
        src.pulse(1'b1, 2);
        counts(3, 2);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h00, 32'(m));
            src.quad(1'b1, 4);
            src.pulse(1'b0, 2);
            counts(0, 0);
        end
    endtask
    task automatic t_enc();
        logic [1:0] tab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
        rst(4'h3, 1'b0);
        apb(1'b1, 8'h08, 32'h2);
        for (int k = 1; k <= 16; k++) begin
            mot(1'b1);
            chk({enc_a, enc_b, enc_z}, {tab[k % 4], (k % 8 == 2) || (k % 8 == 3)});
        end
        for (int j = 1; j < 4; j++) begin
            mot(1'b0);
            chk({enc_a, enc_b}, tab[4 - j]);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ============================================================
    // Main sequence and watchdog
    initial begin
        {clk, psel, penable, pwrite, jmp, mstep, mcw} = '0;
        reset = 1'b1;
        paddr = 8'h0;
        pwdata = 32'h0;
        sw = 4'h0;
        {n_errors, samples_checked, ncw, nccw} = '0;
        t_setup();
        t_regs();
        t_quad();
        t_modes();
        t_enc();
        end_sim();
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule

// ---- verification/pulse_io_properties.sv ----
`timescale 1ns/10ps
module pulse_io_properties (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_chan_a,
    input  wire logic       i_chan_b,
    input  wire logic       i_motor_step,
    input  wire logic       i_motor_cw,
    input  wire logic       o_serial_rs485,
    input  wire logic [3:0] o_node_address,
    input  wire logic       o_autobaud_en,
    input  wire logic       o_setup_valid,
    input  wire logic       o_cmd_step,
    input  wire logic       o_enc_a,
    input  wire logic       o_enc_b,
    input  wire logic       o_enc_z
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [1:0] ab_q;
    logic [2:0] quiet_q;
    // ============================================================
    // Helper state
    always_ff @(posedge i_clk) begin
        ab_q <= {o_enc_a, o_enc_b};
    end
    // Seven quiet cycles outlast the sync and decode delay
    always_ff @(posedge i_clk) begin
        if (i_reset || $changed(i_chan_a) || $changed(i_chan_b)) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    function automatic logic [1:0] cw_next(input logic [1:0] ab);
        case (ab)
            2'h0: return 2'h2;
            2'h2: return 2'h3;
            2'h3: return 2'h1;
            default: return 2'h0;
        endcase
    endfunction
    // ============================================================
    // Assertions
    rs232_zero_a: assert property (o_setup_valid && o_node_address == 4'h0 |-> !o_serial_rs485)
        else $error("zero switch did not give point-to-point mode");
    rs485_node_a: assert property (o_setup_valid && o_node_address != 4'h0 |-> o_serial_rs485)
        else $error("non-zero switch did not give multidrop mode");
    setup_time_a: assert property ($fell(i_reset) |-> ##[1:8] o_setup_valid)
        else $error("power-up capture late");
    setup_once_a: assert property (o_setup_valid |=> o_setup_valid && $stable(o_node_address)
        && $stable(o_autobaud_en))
        else $error("captured setup changed");
    enc_cw_a: assert property (i_motor_step && i_motor_cw |=> {o_enc_a, o_enc_b} == cw_next(ab_q))
        else $error("clockwise phase order wrong");
    enc_ccw_a: assert property (i_motor_step && !i_motor_cw |=> cw_next({o_enc_a, o_enc_b}) == ab_q)
        else $error("counter-clockwise phase order wrong");
    enc_hold_a: assert property (!i_motor_step |=> {o_enc_a, o_enc_b} == ab_q)
        else $error("encoder output moved without a step");
    marker_b_a: assert property (o_enc_z |-> o_enc_b)
        else $error("marker outside channel B pulse");
    quiet_nostep_a: assert property (quiet_q == 3'h7 |-> !o_cmd_step)
        else $error("count without channel activity");
    cover property (o_cmd_step);
    cover property (o_enc_z);
    cover property (o_setup_valid && o_serial_rs485);
    cover property (o_setup_valid && o_autobaud_en);
endmodule

bind pulse_io_top pulse_io_properties props (
    .i_clk(i_clk), .i_reset(i_reset), .i_chan_a(i_chan_a), .i_chan_b(i_chan_b),
    .i_motor_step(i_motor_step), .i_motor_cw(i_motor_cw), .o_serial_rs485(o_serial_rs485),
    .o_node_address(o_node_address), .o_autobaud_en(o_autobaud_en), .o_setup_valid(o_setup_valid),
    .o_cmd_step(o_cmd_step), .o_enc_a(o_enc_a), .o_enc_b(o_enc_b), .o_enc_z(o_enc_z));

// ---- verification/pulse_source.sv ----
`timescale 1ns/10ps
module pulse_source (
    input  wire logic i_clk,
    output logic      o_chan_a,
    output logic      o_chan_b,
    output logic      o_marker
);
    // ============================================================
    // Levels held 4 clocks so the two-flop sync never drops one
    initial begin
        o_chan_a = 1'b0;
        o_chan_b = 1'b0;
        o_marker = 1'b0;
    end
    task automatic lvl(input logic a, input logic b);
        @(posedge i_clk);
        o_chan_a <= a;
        o_chan_b <= b;
        repeat (3) @(posedge i_clk);
    endtask
    // Clockwise: A moves first from equal levels, so A leads
    task automatic quad(input logic cw, input int n);
        for (int k = 0; k < n; k++) begin
            lvl(o_chan_a ^ ((o_chan_a == o_chan_b) == cw), o_chan_b ^ ((o_chan_a == o_chan_b) != cw));
        end
    endtask
    // Illegal on purpose: both channels change together
    task automatic both();
        lvl(~o_chan_a, ~o_chan_b);
    endtask
    task automatic pulse(input logic onb, input int n);
        for (int k = 0; k < n; k++) begin
            lvl(o_chan_a | !onb, o_chan_b | onb);
            lvl(o_chan_a & onb, o_chan_b & !onb);
        end
    endtask
    // Direction level low for clockwise
    task automatic dir(input logic cw, input int n);
        lvl(1'b0, ~cw);
        pulse(1'b0, n);
    endtask
    task automatic mark(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_marker <= ~o_marker;
            repeat (3) @(posedge i_clk);
        end
    endtask
endmodule
